// file: logic/sae_pkg.sv
// constants shared by both ends of the register window address extension
// assumes one clock and a synchronous active-high reset everywhere
//
// Behaviour
// - decode register accesses only from 80 to FF
// - standard and mapped areas, 256 locations total
// - area chosen by map_select at 8F
// - map_select one mapped, zero standard
// - hardware never clears map_select itself
// - control bit 2 read-write, reads back
// - control bits 1 and 7..3 read zero
// - system_map_control resets to 00
// - software changes map_select by and/or only
// - operation upper bit zero writes page directly
// - operation 10 saves old page, stores new
// - operation 11 restores page from slot
// - sysctl page register at BF, layout fixed
// - capcomp page register at A3, same layout
// - sysctl registers standard only; 8F both areas
// - capcomp registers standard, banked by page
// - all registers except counter in window
package sae_pkg;

    // ----------------------------------------------------------------
    // register window
    // ----------------------------------------------------------------
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] ADDR_SYS_MAP = 8'h8f;
    localparam logic [7:0] ADDR_CC_PAGE = 8'ha3;
    localparam logic [7:0] ADDR_SYS_PAGE = 8'hbf;
    localparam logic [7:0] SYS_MAP_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MAP_SELECT_BIT = 0;
    localparam int SYS_KEEP_BIT = 2;
    localparam int OP_HI_BIT = 7;
    localparam int OP_LO_BIT = 6;
    localparam int SLOT_HI_BIT = 5;
    localparam int SLOT_LO_BIT = 4;
    localparam int PAGE_W = 3;
    localparam int SLOT_COUNT = 4;

    // owner of a decoded access: which page value applies
    typedef enum logic [1:0] {
        SAE_OWN_NONE = 2'b00,
        SAE_OWN_SYSCTL = 2'b01,
        SAE_OWN_CAPCOMP = 2'b10
    } sae_owner_t;

    // target of a decoded access
    typedef enum logic [2:0] {
        SAE_TGT_NONE = 3'b000,
        SAE_TGT_SYS_MAP = 3'b001,
        SAE_TGT_SYS_PAGE = 3'b010,
        SAE_TGT_CC_PAGE = 3'b011,
        SAE_TGT_EXT = 3'b100
    } sae_target_t;

    // ----------------------------------------------------------------
    // host-side apb registers
    // ----------------------------------------------------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_RDATA = 8'h08;
    localparam int CMD_ADDR_LO = 0;
    localparam int CMD_DATA_LO = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    // address decode: standard area only for paged module registers
    function automatic sae_owner_t owner_of(input logic [7:0] addr);
        if ((addr >= 8'hb3 && addr <= 8'hbe) || (addr >= 8'he9 && addr <= 8'heb))
        begin
            return SAE_OWN_SYSCTL;
        end
        if ((addr >= 8'h9a && addr <= 8'h9f) || (addr >= 8'ha4 && addr <= 8'ha7)
            || (addr >= 8'hfa))
        begin
            return SAE_OWN_CAPCOMP;
        end
        return SAE_OWN_NONE;
    endfunction

    function automatic sae_target_t target_of(input logic mapped, input logic [7:0] addr);
        if (addr < SFR_BASE)
        begin
            return SAE_TGT_NONE;
        end
        if (addr == ADDR_SYS_MAP)
        begin
            return SAE_TGT_SYS_MAP;
        end
        if (!mapped && addr == ADDR_SYS_PAGE)
        begin
            return SAE_TGT_SYS_PAGE;
        end
        if (!mapped && addr == ADDR_CC_PAGE)
        begin
            return SAE_TGT_CC_PAGE;
        end
        return SAE_TGT_EXT;
    endfunction

endpackage

// file: logic/sae_sfr_if.sv
// register-window access link between the cpu port and the address extension
// assumes both ends on the same clock; req is held until ack
`timescale 1ns/100ps
`default_nettype none
interface sae_sfr_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack
    );

    modport cpu (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack
    );
endinterface
`default_nettype wire

// file: logic/sae_page_reg.sv
// one page register with operation field and save slots
// assumes wr_en_i is a one-cycle write strobe from the same clock
`timescale 1ns/100ps
`default_nettype none
module sae_page_reg #(
    parameter int SLOTS = sae_pkg::SLOT_COUNT
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    output logic [2:0] page_o,
    output logic [7:0] rd_value_o
);
    logic [2:0] page;
    logic [2:0] page_save_slot [SLOTS];
    logic [1:0] page_operation;
    logic [1:0] storage_slot_select;

    assign page_operation = wdata_i[sae_pkg::OP_HI_BIT:sae_pkg::OP_LO_BIT];
    assign storage_slot_select = wdata_i[sae_pkg::SLOT_HI_BIT:sae_pkg::SLOT_LO_BIT];

    // ----------------------------------------------------------------
    // page field
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            page <= sae_pkg::PAGE_RESET[2:0];
        end
        else if (wr_en_i)
        begin
            if (!page_operation[1])
            begin
                page <= wdata_i[2:0];
            end
            else if (!page_operation[0])
            begin
                page <= wdata_i[2:0];
            end
            else
            begin
                page <= page_save_slot[storage_slot_select];
            end
        end
    end

    // ----------------------------------------------------------------
    // save slots
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                page_save_slot[i] <= '0;
            end
        end
        else if (wr_en_i && page_operation == 2'b10)
        begin
            page_save_slot[storage_slot_select] <= page;
        end
    end

    assign page_o = page;
    // operation and slot fields are write-only, bit 3 reads zero
    assign rd_value_o = {5'h0, page};
endmodule
`default_nettype wire

// file: logic/sae_sfr_ext.sv
// address extension end: map control, two page registers and the decoder
// assumes the cpu end holds req with stable fields until ack
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sae_sfr_ext (
    input wire logic core_clk_i,
    input wire logic reset_i,
    sae_sfr_if.dev sfr,
    output logic map_select_o,
    output logic ext_req_o,
    output logic ext_we_o,
    output logic ext_mapped_o,
    output logic [7:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    output var sae_pkg::sae_owner_t ext_owner_o,
    output logic [2:0] ext_page_o,
    input wire logic [7:0] ext_rdata_i
);
    typedef enum logic [2:0] {
        SAE_ST_IDLE = 3'b001,
        SAE_ST_ISSUE = 3'b010,
        SAE_ST_ANSWER = 3'b100
    } sae_state_t;

    sae_state_t state;
    sae_state_t next_state;
    sae_pkg::sae_target_t tgt;
    sae_pkg::sae_target_t tgt_q;
    sae_pkg::sae_owner_t own;
    logic map_select;
    logic sys_keep;
    logic take;
    logic [7:0] int_rdata;
    logic [2:0] sysctl_page_select;
    logic [2:0] cc_page;
    logic [7:0] scu_rd;
    logic [7:0] cc_rd;

    assign take = (state == SAE_ST_IDLE) && sfr.req;
    // one target per access from area and address
    assign tgt = sae_pkg::target_of(map_select, sfr.addr);
    // paged modules live only in the standard area
    assign own = map_select ? sae_pkg::SAE_OWN_NONE : sae_pkg::owner_of(sfr.addr);

    // ----------------------------------------------------------------
    // access sequence
    // ----------------------------------------------------------------
    always_comb
    begin
        case (state)
            SAE_ST_IDLE: next_state = sfr.req ? SAE_ST_ISSUE : SAE_ST_IDLE;
            SAE_ST_ISSUE: next_state = SAE_ST_ANSWER;
            SAE_ST_ANSWER: next_state = SAE_ST_IDLE;
            default: next_state = SAE_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state <= SAE_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // system map control
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            map_select <= sae_pkg::SYS_MAP_RESET[sae_pkg::MAP_SELECT_BIT];
            sys_keep <= sae_pkg::SYS_MAP_RESET[sae_pkg::SYS_KEEP_BIT];
        end
        else if (take && sfr.we && tgt == sae_pkg::SAE_TGT_SYS_MAP)
        begin
            // only software moves it, reachable in both areas
            map_select <= sfr.wdata[sae_pkg::MAP_SELECT_BIT];
            sys_keep <= sfr.wdata[sae_pkg::SYS_KEEP_BIT];
        end
    end

    assign map_select_o = map_select;

    // ----------------------------------------------------------------
    // page registers
    // ----------------------------------------------------------------
    sae_page_reg #(
        .SLOTS(sae_pkg::SLOT_COUNT)
    ) u_sysctl_page_select (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_en_i(take && sfr.we && tgt == sae_pkg::SAE_TGT_SYS_PAGE),
        .wdata_i(sfr.wdata),
        .page_o(sysctl_page_select),
        .rd_value_o(scu_rd)
    );

    sae_page_reg #(
        .SLOTS(sae_pkg::SLOT_COUNT)
    ) u_cc_page (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_en_i(take && sfr.we && tgt == sae_pkg::SAE_TGT_CC_PAGE),
        .wdata_i(sfr.wdata),
        .page_o(cc_page),
        .rd_value_o(cc_rd)
    );

    // ----------------------------------------------------------------
    // outward select, one cycle after the take
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            ext_req_o <= 1'b0;
            ext_we_o <= 1'b0;
            ext_mapped_o <= 1'b0;
            ext_addr_o <= 8'h00;
            ext_wdata_o <= 8'h00;
            ext_owner_o <= sae_pkg::SAE_OWN_NONE;
            ext_page_o <= 3'h0;
            tgt_q <= sae_pkg::SAE_TGT_NONE;
        end
        else
        begin
            ext_req_o <= take && tgt == sae_pkg::SAE_TGT_EXT;
            if (take)
            begin
                tgt_q <= tgt;
                ext_we_o <= sfr.we;
                ext_mapped_o <= map_select;
                ext_addr_o <= sfr.addr;
                ext_wdata_o <= sfr.wdata;
                ext_owner_o <= own;
                case (own)
                    sae_pkg::SAE_OWN_SYSCTL: ext_page_o <= sysctl_page_select;
                    sae_pkg::SAE_OWN_CAPCOMP: ext_page_o <= cc_page;
                    default: ext_page_o <= 3'h0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // read answer
    // ----------------------------------------------------------------
    always_comb
    begin
        case (tgt_q)
            // unused bits of the map register read zero
            sae_pkg::SAE_TGT_SYS_MAP: int_rdata = {5'h00, sys_keep, 1'b0, map_select};
            sae_pkg::SAE_TGT_SYS_PAGE: int_rdata = scu_rd;
            sae_pkg::SAE_TGT_CC_PAGE: int_rdata = cc_rd;
            sae_pkg::SAE_TGT_EXT: int_rdata = ext_rdata_i;
            default: int_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            sfr.rdata <= 8'h00;
            sfr.ack <= 1'b0;
        end
        else
        begin
            sfr.ack <= (state == SAE_ST_ISSUE);
            if (state == SAE_ST_ISSUE)
            begin
                sfr.rdata <= int_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/sae_cpu_port.sv
// cpu end: apb slave whose command register issues one window access
// assumes apb on the same clock; software follows and/or updates of map_select
`timescale 1ns/100ps
`default_nettype none
module sae_cpu_port (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    sae_sfr_if.cpu sfr
);
    logic busy;
    logic done;
    logic [7:0] last_rdata;
    logic acc;
    logic wr_cmd;
    logic clr_done;
    logic mapped_addr;

    assign acc = psel_i && penable_i;
    assign wr_cmd = acc && pwrite_i && paddr_i == sae_pkg::APB_CMD;
    assign clr_done = acc && pwrite_i && paddr_i == sae_pkg::APB_STATUS
        && pwdata_i[sae_pkg::STAT_DONE_BIT];
    assign mapped_addr = paddr_i == sae_pkg::APB_CMD || paddr_i == sae_pkg::APB_STATUS
        || paddr_i == sae_pkg::APB_RDATA;
    // zero wait states
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped_addr;

    // ----------------------------------------------------------------
    // issue one access; a command while busy is dropped
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            busy <= 1'b0;
            sfr.req <= 1'b0;
            sfr.we <= 1'b0;
            sfr.addr <= 8'h00;
            sfr.wdata <= 8'h00;
        end
        else if (busy)
        begin
            if (sfr.ack)
            begin
                busy <= 1'b0;
                sfr.req <= 1'b0;
            end
        end
        else if (wr_cmd)
        begin
            busy <= 1'b1;
            sfr.req <= 1'b1;
            sfr.we <= pwdata_i[sae_pkg::CMD_WRITE_BIT];
            sfr.addr <= pwdata_i[sae_pkg::CMD_ADDR_LO +: 8];
            sfr.wdata <= pwdata_i[sae_pkg::CMD_DATA_LO +: 8];
        end
    end

    // done flag: a completion in the clearing cycle wins
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            done <= 1'b0;
            last_rdata <= 8'h00;
        end
        else if (busy && sfr.ack)
        begin
            done <= 1'b1;
            last_rdata <= sfr.rdata;
        end
        else if (clr_done)
        begin
            done <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            case (paddr_i)
                sae_pkg::APB_STATUS: prdata_o <= {30'h0000_0000, done, busy};
                sae_pkg::APB_RDATA: prdata_o <= {24'h00_0000, last_rdata};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: test/sae_sfr_sva.sv
// checker for the window access link between cpu end and address extension
// assumes one clock, sync active-high reset, link signals taken as plain inputs
`timescale 1ns/100ps
`default_nettype none
module sae_sfr_sva (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // ----------------------------------------------------------------
    // mirror of the map control bits, fed only by completed writes
    // ----------------------------------------------------------------
    logic map_q;
    logic keep_q;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            map_q <= 1'b0;
            keep_q <= 1'b0;
        end
        else if (ack && we && addr == sae_pkg::ADDR_SYS_MAP)
        begin
            map_q <= wdata[sae_pkg::MAP_SELECT_BIT];
            keep_q <= wdata[sae_pkg::SYS_KEEP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // handshake and read values
    // ----------------------------------------------------------------
    sequence s_take;
        $rose(req);
    endsequence
    sequence s_answer;
        !ack ##1 ack;
    endsequence
    sequence s_map_read;
        ack && !we && addr == sae_pkg::ADDR_SYS_MAP;
    endsequence
    sequence s_page_read;
        ack && !we && !map_q
            && (addr == sae_pkg::ADDR_SYS_PAGE || addr == sae_pkg::ADDR_CC_PAGE);
    endsequence

    a_ack_after_take: assert property (s_take |-> ##1 s_answer)
        else $error("ack not two cycles after take");
    a_req_held: assert property (req && !ack |=> req && $stable({addr, we, wdata}))
        else $error("request changed before ack");
    a_req_drops: assert property (ack |=> !req)
        else $error("request not dropped after ack");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (ack |-> req)
        else $error("ack without request");
    a_reset_idle: assert property ($past(reset_i) |-> !req && !ack)
        else $error("link not idle after reset");
    a_low_reads_zero: assert property (ack && !we && addr < 8'h80 |-> rdata == 8'h00)
        else $error("read below window not zero");
    a_map_readback: assert property (s_map_read
        |-> rdata == {5'h00, keep_q, 1'b0, map_q})
        else $error("map control read value wrong");
    a_page_reserved: assert property (s_page_read |-> rdata[7:3] == 5'h00)
        else $error("page register upper bits not zero");
endmodule
`default_nettype wire

// file: test/sfr_address_extension_test.sv
// testbench: apb host drives the cpu end, which reaches the address extension
// assumes the ext side answers from ext_rdata, set by the bench before each access
`timescale 1ns/100ps
`default_nettype none
module sfr_address_extension_test;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] ext_rdata = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, map_sel, ext_req, ext_we, ext_mapped;
    logic [7:0] ext_addr, ext_wdata;
    sae_pkg::sae_owner_t ext_owner;
    logic [2:0] ext_page;
    logic m_we, m_mapped, last_err;
    logic [7:0] m_addr, m_wdata, rd;
    logic [1:0] m_owner;
    logic [2:0] m_page;
    logic [31:0] word;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int ext_cnt = 0;

    sae_sfr_if i_sae_sfr_if ();
    sae_sfr_ext i_sae_sfr_ext (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .sfr(i_sae_sfr_if.dev), .map_select_o(map_sel), .ext_req_o(ext_req),
        .ext_we_o(ext_we), .ext_mapped_o(ext_mapped), .ext_addr_o(ext_addr),
        .ext_wdata_o(ext_wdata), .ext_owner_o(ext_owner), .ext_page_o(ext_page),
        .ext_rdata_i(ext_rdata));
    sae_cpu_port i_sae_cpu_port (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sfr(i_sae_sfr_if.cpu));
    sae_sfr_sva i_sae_sfr_sva (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .req(i_sae_sfr_if.req), .we(i_sae_sfr_if.we), .addr(i_sae_sfr_if.addr),
        .wdata(i_sae_sfr_if.wdata), .rdata(i_sae_sfr_if.rdata), .ack(i_sae_sfr_if.ack));

    initial
    begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------------------------------
    // ext side monitor and hang guard
    // ----------------------------------------------------------------
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (ext_req === 1'b1)
        begin
            ext_cnt++;
            {m_we, m_mapped, m_addr, m_wdata, m_owner, m_page} =
                {ext_we, ext_mapped, ext_addr, ext_wdata, ext_owner, ext_page};
        end
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, takes data and error at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1)
        begin
            @(posedge core_clk_i);
        end
        word = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one window access through the command register, then status and read data
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, sae_pkg::APB_CMD, {15'h0000, w, d, a});
        n = 0;
        word = 32'h0000_0000;
        while (word[sae_pkg::STAT_DONE_BIT] !== 1'b1 && n < 20)
        begin
            apb(1'b0, sae_pkg::APB_STATUS, 32'h0000_0000);
            n++;
        end
        check_byte({7'h00, word[sae_pkg::STAT_DONE_BIT]}, 8'h01);
        apb(1'b1, sae_pkg::APB_STATUS, 32'h0000_0002);
        apb(1'b0, sae_pkg::APB_RDATA, 32'h0000_0000);
        rd = word[7:0];
    endtask

    task automatic check_ext(input int n0, input logic w, input logic mp, input logic [7:0] a,
        input logic [7:0] d, input sae_pkg::sae_owner_t own, input logic [2:0] pg);
        check_byte(8'(ext_cnt - n0), 8'h01);
        check_byte({6'h00, m_we, m_mapped}, {6'h00, w, mp});
        check_byte(m_addr, a);
        check_byte({3'h0, m_owner, m_page}, {3'h0, own, pg});
        check_byte(w ? m_wdata : rd, d);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int n0;
        logic [7:0] a;
        logic [7:0] op_w [6];
        logic [7:0] op_e [6];
        logic [7:0] ex_a [6];
        sae_pkg::sae_owner_t ex_o [6];
        logic [2:0] ex_p [6];
        op_w = '{8'h0d, 8'h73, 8'ha6, 8'h91, 8'he7, 8'hd0};
        op_e = '{8'h05, 8'h03, 8'h06, 8'h01, 8'h03, 8'h06};
        ex_a = '{8'hb4, 8'heb, 8'h9a, 8'hff, 8'hc2, 8'h80};
        ex_o = '{sae_pkg::SAE_OWN_SYSCTL, sae_pkg::SAE_OWN_SYSCTL, sae_pkg::SAE_OWN_CAPCOMP,
            sae_pkg::SAE_OWN_CAPCOMP, sae_pkg::SAE_OWN_NONE, sae_pkg::SAE_OWN_NONE};
        ex_p = '{3'h6, 3'h6, 3'h2, 3'h2, 3'h0, 3'h0};
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        sfr(1'b0, sae_pkg::ADDR_SYS_MAP, 8'h00);
        check_byte(rd, 8'h00);
        check_byte({7'h00, map_sel}, 8'h00);
        n0 = ext_cnt;
        sfr(1'b1, 8'h40, 8'h5a);
        sfr(1'b0, 8'h40, 8'h00);
        check_byte(rd, 8'h00);
        check_byte(8'(ext_cnt - n0), 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            a = (i == 0) ? sae_pkg::ADDR_SYS_PAGE : sae_pkg::ADDR_CC_PAGE;
            sfr(1'b0, a, 8'h00);
            check_byte(rd, 8'h00);
            for (int j = 0; j < 6; j++)
            begin
                sfr(1'b1, a, op_w[j]);
                sfr(1'b0, a, 8'h00);
                check_byte(rd, op_e[j]);
            end
        end
        sfr(1'b1, sae_pkg::ADDR_CC_PAGE, 8'h02);
        for (int k = 0; k < 6; k++)
        begin
            ext_rdata <= 8'hc0 + 8'(k);
            n0 = ext_cnt;
            sfr(k[0], ex_a[k], 8'h30 + 8'(k));
            check_ext(n0, k[0], 1'b0, ex_a[k], k[0] ? 8'h30 + 8'(k) : 8'hc0 + 8'(k),
                ex_o[k], ex_p[k]);
        end
        // all bits set on purpose: reserved ones must stay zero
        sfr(1'b1, sae_pkg::ADDR_SYS_MAP, 8'hff);
        check_byte({7'h00, map_sel}, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            ext_rdata <= 8'h77;
            n0 = ext_cnt;
            sfr(1'b0, ex_a[k] | {8{k == 0}} & sae_pkg::ADDR_SYS_PAGE, 8'h00);
            check_ext(n0, 1'b0, 1'b1, k == 0 ? sae_pkg::ADDR_SYS_PAGE : ex_a[k], 8'h77,
                sae_pkg::SAE_OWN_NONE, 3'h0);
        end
        sfr(1'b0, sae_pkg::ADDR_SYS_MAP, 8'h00);
        check_byte(rd, 8'h05);
        sfr(1'b1, sae_pkg::ADDR_SYS_MAP, rd & 8'hfe);
        check_byte({7'h00, map_sel}, 8'h00);
        sfr(1'b0, sae_pkg::ADDR_SYS_PAGE, 8'h00);
        check_byte(rd, 8'h06);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check_byte({7'h00, last_err}, 8'h01);
        check_word(word, 32'h0000_0000);
        end_sim();
    end
endmodule
`default_nettype wire
